/* File: bpl_loader.sv */
// byte-parallel configuration load port with its dual-clock byte buffer
// Function
// - one whole byte per load clock cycle
// - patterns 1110/1111 pick byte load, voltage
// - power-on reset length follows scheme select
// - power-on reset holds status low, I/O off
// - I/O tristated until user mode, pull-ups on from end of power-on reset until user mode
// - request or status low keeps reset stage
// - request high releases status for patterns 1110/1111, load may start
// - data captured on load clock rising edge
// - load complete released after next-to-last byte
// - load complete rise means only the last byte is left to load
// - error drives status low, resets internally
// - auto restart releases status within 230 us
// - external start-up clock needs 3187 init cycles
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// dual-clock buffer, gray pointers, depth a power of two, at least 4
// ---------------------------------------------------------------------
module bpl_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             i_wr_clk,
   input  wire logic             i_rd_clk,
   input  wire logic             i_rst,
   input  wire logic             i_wr_valid,
   input  wire logic [WIDTH-1:0] i_wr_data,
   output logic                  o_wr_ready,
   output logic                  o_rd_valid,
   output logic [WIDTH-1:0]      o_rd_data,
   input  wire logic             i_rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wbin_q;
   logic [AW:0]      wgray_q;
   logic [AW:0]      rbin_q;
   logic [AW:0]      rgray_q;
   logic [AW:0]      wbin_d;
   logic [AW:0]      rbin_d;
   logic [AW:0]      rg_s1_q;
   logic [AW:0]      rg_s2_q;
   logic [AW:0]      wg_s1_q;
   logic [AW:0]      wg_s2_q;

   // full when write pointer leads read pointer by one lap
   assign o_wr_ready = (wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
   assign o_rd_valid = (rgray_q != wg_s2_q);
   assign o_rd_data  = mem_q[rbin_q[AW-1:0]];
   assign wbin_d     = wbin_q + 1'b1;
   assign rbin_d     = rbin_q + 1'b1;

   // write pointer, link clock
   always_ff @(posedge i_wr_clk or posedge i_rst) begin
      if (i_rst) begin
         wbin_q  <= '0;
         wgray_q <= '0;
      end else if (i_wr_valid && o_wr_ready) begin
         wbin_q  <= wbin_d;
         wgray_q <= wbin_d ^ (wbin_d >> 1);
      end
   end

   // storage
   always_ff @(posedge i_wr_clk) begin
      if (i_wr_valid && o_wr_ready) begin
         mem_q[wbin_q[AW-1:0]] <= i_wr_data;
      end
   end

   // read pointer, system clock
   always_ff @(posedge i_rd_clk or posedge i_rst) begin
      if (i_rst) begin
         rbin_q  <= '0;
         rgray_q <= '0;
      end else if (o_rd_valid && i_rd_ready) begin
         rbin_q  <= rbin_d;
         rgray_q <= rbin_d ^ (rbin_d >> 1);
      end
   end

   // read pointer into the write domain
   always_ff @(posedge i_wr_clk or posedge i_rst) begin
      if (i_rst) begin
         rg_s1_q <= '0;
         rg_s2_q <= '0;
      end else begin
         rg_s1_q <= rgray_q;
         rg_s2_q <= rg_s1_q;
      end
   end

   // write pointer into the read domain
   always_ff @(posedge i_rd_clk or posedge i_rst) begin
      if (i_rst) begin
         wg_s1_q <= '0;
         wg_s2_q <= '0;
      end else begin
         wg_s1_q <= wgray_q;
         wg_s2_q <= wg_s1_q;
      end
   end
endmodule

// ---------------------------------------------------------------------
// configuration load port
// ---------------------------------------------------------------------
module bpl_loader #(
   parameter int unsigned P_POR_FAST_CYC = bpl_pkg::POR_FAST_CYC,
   parameter int unsigned P_POR_STD_CYC  = bpl_pkg::POR_STD_CYC,
   parameter int unsigned P_RESTART_CYC  = bpl_pkg::RESTART_CYC,
   parameter int unsigned P_INIT_INT_CYC = bpl_pkg::INIT_INT_CYC,
   parameter int unsigned P_STREAM_BYTES = bpl_pkg::STREAM_BYTES,
   parameter logic [7:0]  P_SYNC_BYTE    = bpl_pkg::SYNC_BYTE,
   parameter int          P_FIFO_DEPTH   = bpl_pkg::FIFO_DEPTH
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_load_clock,
   input  wire logic [7:0] i_load_data,
   input  wire logic       i_config_request_n,
   input  wire logic       i_status,
   input  wire logic [3:0] i_scheme_select,
   input  wire logic       i_auto_restart,
   input  wire logic       i_use_ext_startup,
   input  wire logic       i_external_startup_clock,
   output logic            o_status_out,
   output logic            o_status_oe,
   output logic            o_load_complete_out,
   output logic            o_load_complete_oe,
   output logic            o_user_io_oe,
   output logic            o_weak_pullup_en,
   output logic            o_low_voltage_std,
   output logic            o_user_mode,
   output logic            o_config_error
);
   localparam int SW = 11;
   logic [SW-1:0]       sync_in;
   logic [SW-1:0]       sync_s1_q;
   logic [SW-1:0]       sync_s2_q;
   logic                eclk_s3_q;
   logic                ovf_s3_q;
   logic                req_s;
   logic                stat_s;
   logic [3:0]          sel_s;
   logic                auto_s;
   logic                ext_s;
   logic                eclk_s;
   logic                ovf_s;
   logic                go_s;
   bpl_pkg::bpl_stage_t state_q;
   bpl_pkg::bpl_stage_t state_d;
   logic [31:0]         tmr_q;
   logic [31:0]         byte_cnt_q;
   logic [3:0]          sel_q;
   logic                init_ext_q;
   logic                busy_q;
   logic                done_rel_q;
   logic                load_lvl_q;
   logic                done_lvl_q;
   logic                rel_d;
   logic                scheme_ok;
   logic                eclk_edge;
   logic                ovf_ev;
   logic                pop;
   logic                rd_ready;
   logic                rd_valid;
   logic                err_ev;
   logic                ntl_pop;
   logic                last_pop;
   logic [31:0]         por_len;
   logic [31:0]         init_len;
   logic                ld_s1_q;
   logic                ld_s2_q;
   logic                dn_s1_q;
   logic                dn_s2_q;
   logic                first_q;
   logic                ovf_tgl_q;
   logic                init_go_q;
   logic [1:0]          fall_cnt_q;
   logic                wr_ready;
   bpl_pkg::bpl_byte_t  wr_word;
   bpl_pkg::bpl_byte_t  rd_word;

   // ------------------------------------------------------------------
   // link side, runs on the host's load clock
   // ------------------------------------------------------------------
   // load stage level into the link domain: raised at once, since the load clock
   // stands still until the host sees status high; lowered after two edges
   always_ff @(posedge i_load_clock or posedge i_rst or posedge load_lvl_q) begin
      if (i_rst) begin
         ld_s1_q <= 1'b0;
         ld_s2_q <= 1'b0;
      end else if (load_lvl_q) begin
         ld_s1_q <= 1'b1;
         ld_s2_q <= 1'b1;
      end else begin
         ld_s1_q <= 1'b0;
         ld_s2_q <= ld_s1_q;
      end
   end

   // completion level into the link domain, raised the same way, so that the
   // falling edges right after the release are counted
   always_ff @(posedge i_load_clock or posedge i_rst or posedge done_lvl_q) begin
      if (i_rst) begin
         dn_s1_q <= 1'b0;
         dn_s2_q <= 1'b0;
      end else if (done_lvl_q) begin
         dn_s1_q <= 1'b1;
         dn_s2_q <= 1'b1;
      end else begin
         dn_s1_q <= 1'b0;
         dn_s2_q <= dn_s1_q;
      end
   end

   // first-byte marker and overflow event toggle
   always_ff @(posedge i_load_clock or posedge i_rst) begin
      if (i_rst) begin
         first_q   <= 1'b1;
         ovf_tgl_q <= 1'b0;
      end else begin
         if (!ld_s2_q) begin
            first_q <= 1'b1;  // edges outside the load stage are dropped
         end else if (wr_ready) begin
            first_q <= 1'b0;
         end
         if (ld_s2_q && !wr_ready) begin
            ovf_tgl_q <= ~ovf_tgl_q;  // byte arrived with buffer full
         end
      end
   end

   // falling edges after completion open initialization on the external start-up clock
   always_ff @(negedge i_load_clock or posedge i_rst) begin
      if (i_rst) begin
         fall_cnt_q <= 2'h0;
         init_go_q  <= 1'b0;
      end else if (!dn_s2_q) begin
         fall_cnt_q <= 2'h0;
         init_go_q  <= 1'b0;
      end else if (fall_cnt_q != bpl_pkg::LINK_FALL_EDGES) begin
         fall_cnt_q <= fall_cnt_q + 2'h1;
         init_go_q  <= (fall_cnt_q + 2'h1 == bpl_pkg::LINK_FALL_EDGES);
      end
   end

   // one byte per rising load clock edge while loading
   assign wr_word = '{first: first_q, data: i_load_data};

   bpl_fifo #(
      .WIDTH ($bits(bpl_pkg::bpl_byte_t)),
      .DEPTH (P_FIFO_DEPTH)
   ) u_fifo (
      .i_wr_clk   (i_load_clock),
      .i_rd_clk   (i_clk),
      .i_rst      (i_rst),
      .i_wr_valid (ld_s2_q),
      .i_wr_data  (wr_word),
      .o_wr_ready (wr_ready),
      .o_rd_valid (rd_valid),
      .o_rd_data  (rd_word),
      .i_rd_ready (rd_ready)
   );

   // ------------------------------------------------------------------
   // pin synchronisers, system clock
   // ------------------------------------------------------------------
   assign sync_in = {i_config_request_n, i_status, i_scheme_select, i_auto_restart,
                     i_use_ext_startup, i_external_startup_clock, ovf_tgl_q, init_go_q};
   assign {req_s, stat_s, sel_s, auto_s, ext_s, eclk_s, ovf_s, go_s} = sync_s2_q;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync_s1_q <= '0;
         sync_s2_q <= '0;
         eclk_s3_q <= 1'b0;
         ovf_s3_q  <= 1'b0;
      end else begin
         sync_s1_q <= sync_in;
         sync_s2_q <= sync_s1_q;
         eclk_s3_q <= eclk_s;
         ovf_s3_q  <= ovf_s;
      end
   end

   // ------------------------------------------------------------------
   // stage decode
   // ------------------------------------------------------------------
   assign scheme_ok = (sel_q == bpl_pkg::SCHEME_BPL_HI_V) ||
                      (sel_q == bpl_pkg::SCHEME_BPL_LO_V);
   assign por_len   = scheme_ok ? P_POR_FAST_CYC : P_POR_STD_CYC;
   assign init_len  = init_ext_q ? bpl_pkg::INIT_EXT_CYC : P_INIT_INT_CYC;
   assign eclk_edge = eclk_s & ~eclk_s3_q;
   assign ovf_ev    = ovf_s ^ ovf_s3_q;
   // the frame writer takes two cycles per byte, so it stalls the buffer
   assign rd_ready  = !((state_q == bpl_pkg::ST_LOAD) && busy_q);
   assign pop       = rd_valid && rd_ready;
   // the count decides which byte opens the stream, the marker only backs it up
   assign err_ev    = ovf_ev || (pop && (rd_word.first || (byte_cnt_q == 32'h0000_0000)) &&
                                 (rd_word.data != P_SYNC_BYTE));
   assign ntl_pop   = pop && (byte_cnt_q == P_STREAM_BYTES - 2);
   assign last_pop  = pop && (byte_cnt_q == P_STREAM_BYTES - 1);

   // next stage
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         bpl_pkg::ST_POR: begin
            if (tmr_q > bpl_pkg::POR_STRAP_CYC && tmr_q >= por_len) begin
               state_d = bpl_pkg::ST_RESET;
            end
         end
         bpl_pkg::ST_RESET: begin
            if (req_s && scheme_ok && stat_s) begin
               state_d = bpl_pkg::ST_LOAD;
            end
         end
         bpl_pkg::ST_LOAD: begin
            if (!stat_s) begin
               state_d = bpl_pkg::ST_RESET;
            end else if (err_ev) begin
               state_d = bpl_pkg::ST_ERROR;
            end else if (last_pop) begin
               state_d = bpl_pkg::ST_INIT;
            end
         end
         bpl_pkg::ST_INIT: begin
            if (!stat_s) begin
               state_d = bpl_pkg::ST_RESET;
            end else if (tmr_q >= init_len) begin
               state_d = bpl_pkg::ST_USER;
            end
         end
         bpl_pkg::ST_USER: begin
            state_d = bpl_pkg::ST_USER;
         end
         bpl_pkg::ST_ERROR: begin
            if (auto_s && tmr_q >= P_RESTART_CYC) begin
               state_d = bpl_pkg::ST_RESET;
            end
         end
         default: begin
            state_d = bpl_pkg::ST_RESET;
         end
      endcase
      if (state_q != bpl_pkg::ST_POR && !req_s) begin
         state_d = bpl_pkg::ST_RESET;
      end
   end

   // stage register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= bpl_pkg::ST_POR;
      end else begin
         state_q <= state_d;
      end
   end

   // stage timer: power-on, restart and initialization counts
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tmr_q <= '0;
      end else if (state_d != state_q) begin
         tmr_q <= '0;
      end else if ((state_q == bpl_pkg::ST_POR) ||
                   (state_q == bpl_pkg::ST_ERROR && auto_s) ||
                   (state_q == bpl_pkg::ST_INIT &&
                    (!init_ext_q || (go_s && eclk_edge)))) begin
         tmr_q <= tmr_q + 32'h0000_0001;
      end
   end

   // scheme strap caught after release, start-up clock choice per attempt
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sel_q      <= 4'h0;
         init_ext_q <= 1'b0;
      end else begin
         if (state_q == bpl_pkg::ST_POR && tmr_q == bpl_pkg::POR_STRAP_CYC) begin
            sel_q <= sel_s;
         end
         if (state_q != bpl_pkg::ST_INIT) begin
            init_ext_q <= ext_s;
         end
      end
   end

   // byte count and completion release, cleared outside loading
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         byte_cnt_q <= '0;
         busy_q     <= 1'b0;
         done_rel_q <= 1'b0;
      end else if (state_d != bpl_pkg::ST_LOAD) begin
         byte_cnt_q <= '0;
         busy_q     <= 1'b0;
         done_rel_q <= 1'b0;
      end else begin
         busy_q <= pop;
         if (pop) begin
            byte_cnt_q <= byte_cnt_q + 32'h0000_0001;
         end
         if (ntl_pop) begin
            done_rel_q <= 1'b1;
         end
      end
   end

   // load complete released one byte before the end of the stream
   assign rel_d = (state_d == bpl_pkg::ST_INIT) || (state_d == bpl_pkg::ST_USER) ||
                  ((state_d == bpl_pkg::ST_LOAD) && (done_rel_q || ntl_pop));

   // registered pin drives
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_status_out        <= 1'b0;
         o_status_oe         <= 1'b1;
         o_load_complete_out <= 1'b0;
         o_load_complete_oe  <= 1'b1;
         o_user_io_oe        <= 1'b0;
         o_weak_pullup_en    <= 1'b0;
         o_low_voltage_std   <= 1'b0;
         o_user_mode         <= 1'b0;
         o_config_error      <= 1'b0;
         load_lvl_q          <= 1'b0;
         done_lvl_q          <= 1'b0;
      end else begin
         o_status_out        <= 1'b0;  // open drain: only ever pulls low
         o_status_oe         <= (state_d == bpl_pkg::ST_POR) ||
                                (state_d == bpl_pkg::ST_ERROR) ||
                                ((state_d == bpl_pkg::ST_RESET) && !(req_s && scheme_ok));
         o_load_complete_out <= 1'b0;
         o_load_complete_oe  <= !rel_d;
         o_user_io_oe        <= (state_d == bpl_pkg::ST_USER);
         o_weak_pullup_en    <= (state_d != bpl_pkg::ST_POR) &&
                                (state_d != bpl_pkg::ST_USER);
         o_low_voltage_std   <= (sel_q == bpl_pkg::SCHEME_BPL_LO_V);
         o_user_mode         <= (state_d == bpl_pkg::ST_USER);
         o_config_error      <= (state_d == bpl_pkg::ST_ERROR);
         load_lvl_q          <= (state_d == bpl_pkg::ST_LOAD);
         done_lvl_q          <= rel_d;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_por_hold;
      @(posedge i_clk) disable iff (i_rst)
      state_q == bpl_pkg::ST_POR |-> o_status_oe && !o_user_io_oe && !o_weak_pullup_en;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("pins not held in power-on reset");

   property p_por_len;
      @(posedge i_clk) disable iff (i_rst)
      $fell(state_q == bpl_pkg::ST_POR) |-> $past(tmr_q) >= por_len;
   endproperty
   a_por_len: assert property (p_por_len) else $error("power-on reset ended early");

   property p_req_low;
      @(posedge i_clk) disable iff (i_rst)
      !req_s && state_q != bpl_pkg::ST_POR |=> state_q == bpl_pkg::ST_RESET && o_status_oe;
   endproperty
   a_req_low: assert property (p_req_low) else $error("request low did not reset");

   property p_release;
      @(posedge i_clk) disable iff (i_rst)
      state_q == bpl_pkg::ST_RESET && req_s && scheme_ok |=> !o_status_oe;
   endproperty
   a_release: assert property (p_release) else $error("status not released");

   property p_early_done;
      @(posedge i_clk) disable iff (i_rst)
      state_q == bpl_pkg::ST_LOAD && byte_cnt_q <= P_STREAM_BYTES - 2 |-> o_load_complete_oe;
   endproperty
   a_early_done: assert property (p_early_done) else $error("load complete released early");

   property p_ntl_release;
      @(posedge i_clk) disable iff (i_rst)
      state_q == bpl_pkg::ST_LOAD && ntl_pop && !err_ev && stat_s && req_s
      |=> !o_load_complete_oe [*2];
   endproperty
   a_ntl_release: assert property (p_ntl_release) else $error("load complete not released");

   property p_error;
      @(posedge i_clk) disable iff (i_rst)
      state_q == bpl_pkg::ST_LOAD && err_ev && stat_s && req_s
      |=> o_status_oe && o_config_error && o_load_complete_oe;
   endproperty
   a_error: assert property (p_error) else $error("error did not pull status low");

   property p_restart;
      @(posedge i_clk) disable iff (i_rst)
      state_q == bpl_pkg::ST_ERROR && auto_s |-> tmr_q <= P_RESTART_CYC;
   endproperty
   a_restart: assert property (p_restart) else $error("restart timeout overrun");

   property p_init_ext;
      @(posedge i_clk) disable iff (i_rst)
      $rose(state_q == bpl_pkg::ST_USER) && $past(init_ext_q)
      |-> $past(tmr_q) == bpl_pkg::INIT_EXT_CYC;
   endproperty
   a_init_ext: assert property (p_init_ext) else $error("wrong start-up clock count");

   property p_pullups;
      @(posedge i_clk) disable iff (i_rst)
      state_q == bpl_pkg::ST_LOAD || state_q == bpl_pkg::ST_INIT
      |-> o_weak_pullup_en && !o_user_io_oe;
   endproperty
   a_pullups: assert property (p_pullups) else $error("pins not tristated with pull-ups");

   property p_reset_clear;
      @(posedge i_clk) disable iff (i_rst)
      state_q == bpl_pkg::ST_RESET |-> byte_cnt_q == 0 && !done_rel_q && o_load_complete_oe;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("partial stream kept");
endmodule

/* File: bpl_pkg.sv */
// constants and types shared by the byte-parallel configuration loader
package bpl_pkg;
   // ----------------------------------------------------------------
   // clock and timing figures
   // ----------------------------------------------------------------
   localparam longint unsigned CLK_HZ          = 40_000_000;
   localparam longint unsigned POR_FAST_MIN_MS = 3;
   localparam longint unsigned POR_FAST_MAX_MS = 9;
   localparam longint unsigned POR_STD_MIN_MS  = 50;
   localparam longint unsigned POR_STD_MAX_MS  = 200;
   localparam longint unsigned RESTART_MAX_US  = 230;
   // least times round up, longest times round down
   localparam int unsigned POR_FAST_CYC = int'((POR_FAST_MIN_MS * CLK_HZ + 999) / 1000);
   localparam int unsigned POR_STD_CYC  = int'((POR_STD_MIN_MS * CLK_HZ + 999) / 1000);
   localparam int unsigned RESTART_CYC  = int'((RESTART_MAX_US * CLK_HZ) / 1_000_000);
   localparam int unsigned INIT_EXT_CYC = 3187;
   localparam int unsigned INIT_INT_CYC = 32'h0000_0C73;
   localparam logic [31:0] POR_STRAP_CYC = 32'h0000_0003;
   localparam logic [1:0]  LINK_FALL_EDGES = 2'h2;

   // ----------------------------------------------------------------
   // scheme select patterns and stream defaults
   // ----------------------------------------------------------------
   localparam logic [3:0]  SCHEME_BPL_HI_V = 4'hE;
   localparam logic [3:0]  SCHEME_BPL_LO_V = 4'hF;
   localparam int unsigned STREAM_BYTES    = 32'h0000_0010;
   localparam logic [7:0]  SYNC_BYTE       = 8'h5A;  // arbitrary value
   localparam int          FIFO_DEPTH      = 32'h0000_0004;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_POR   = 3'b000,
      ST_RESET = 3'b001,
      ST_LOAD  = 3'b010,
      ST_INIT  = 3'b011,
      ST_USER  = 3'b100,
      ST_ERROR = 3'b101
   } bpl_stage_t;

   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } bpl_byte_t;
endpackage

/* File: bpl_host.sv */
// host model: request-side wires, load clock and configuration bytes
`timescale 1ns/1ps
module bpl_host (
   input  wire logic  i_status_oe,
   input  wire logic  i_load_complete_oe,
   output logic       o_status,
   output logic       o_load_complete,
   output logic       o_load_clock = 1'b0,
   output logic [7:0] o_load_data  = 8'h00
);
   // open-drain wires with pull-ups
   assign o_status        = ~i_status_oe;
   assign o_load_complete = ~i_load_complete_oe;
   // one 3 ns clock pulse per byte, pause lets the buffer drain
   task automatic send(input logic [7:0] b);
      o_load_data = b;
      #3 o_load_clock = 1'b1;
      #3 o_load_clock = 1'b0;
      o_load_data = ~b;
      #200;
   endtask
   // falling edges after completion
   task automatic finish();
      repeat (2) begin
         #3 o_load_clock = 1'b1;
         #3 o_load_clock = 1'b0;
      end
   endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the byte-parallel configuration loader
`timescale 1ns/1ps
module testbench;
   logic       i_clk  = 1'b0;
   logic       i_rst  = 1'b1;
   logic       req_n  = 1'b0;
   logic       auto_r = 1'b0;
   logic [3:0] scheme = 4'h0;
   logic       ext    = 1'b0;
   logic       eclk   = 1'b0;
   logic [7:0] ldata;
   logic       stat, lc, lclk, st_oe, lc_oe, io_oe, pu_en, lv, user, err;
   int         fails   = 0;
   int         n_tests = 0;
   logic [4:0] expq[$];
   always #12.5 i_clk = ~i_clk;
   // free-running start-up clock, 10 MHz, slow enough for the pin synchroniser
   always #50 eclk = ~eclk;
   bpl_loader #(.P_POR_FAST_CYC(20), .P_POR_STD_CYC(40), .P_RESTART_CYC(30),
      .P_INIT_INT_CYC(10), .P_STREAM_BYTES(6)) u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_load_clock(lclk), .i_load_data(ldata),
      .i_config_request_n(req_n), .i_status(stat), .i_scheme_select(scheme),
      .i_auto_restart(auto_r), .i_use_ext_startup(ext), .i_external_startup_clock(eclk),
      .o_status_out(), .o_status_oe(st_oe), .o_load_complete_out(),
      .o_load_complete_oe(lc_oe), .o_user_io_oe(io_oe), .o_weak_pullup_en(pu_en),
      .o_low_voltage_std(lv), .o_user_mode(user), .o_config_error(err));
   bpl_host u_host (.i_status_oe(st_oe), .i_load_complete_oe(lc_oe), .o_status(stat),
      .o_load_complete(lc), .o_load_clock(lclk), .o_load_data(ldata));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // reset with a strap, check power-on and reset stages, then raise request
   task automatic boot(input logic [3:0] s);
      i_rst  = 1'b1;
      req_n  = 1'b0;
      scheme = s;
      repeat (16) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (6) @(negedge i_clk);
      chk({st_oe, lc_oe, io_oe, pu_en}, 4'hC);
      repeat (60) @(negedge i_clk);
      chk({st_oe, pu_en, io_oe, lv}, {3'b110, s == 4'hF});
      req_n = 1'b1;
   endtask
   // wait for status, note the outcome, send a stream (first byte only if error)
   task automatic full(input logic [4:0] e, input logic [7:0] first);
      for (int i = 0; i < 60 && stat !== 1'b1; i++) @(negedge i_clk);
      chk(stat, 1'b1);
      repeat (20) @(negedge i_clk);
      expq.push_back(e);
      u_host.send(first);
      for (int i = 1; i < 6 && e[4] == 1'b0; i++) begin
         chk(lc, i == 5);
         u_host.send(8'($urandom));
      end
      u_host.finish();
      for (int i = 0; i < 14000 && (user | err) !== 1'b1; i++) @(negedge i_clk);
      chk(user | err, 1'b1);
      repeat (30) @(negedge i_clk);
   endtask
   // each completion or error is matched with the oldest note
   always @(posedge user or posedge err) begin
      #1;
      chk({err, user, io_oe, pu_en, st_oe}, expq.size() ? expq.pop_front() : 5'h1F);
   end
   initial begin
      void'($urandom(32'h774d));
      boot(4'h0);
      repeat (40) @(negedge i_clk);
      chk(stat, 1'b0);
      for (int k = 0; k < 2; k++) begin
         boot(4'hE + 4'(k));
         ext = 1'(k);  // second load counts start-up clock edges
         full(5'b01100, bpl_pkg::SYNC_BYTE);
      end
      req_n = 1'b0;
      ext   = 1'b0;
      repeat (8) @(negedge i_clk);
      chk({st_oe, lc_oe, io_oe}, 3'b110);
      auto_r = 1'b1;
      req_n  = 1'b1;
      full(5'b10011, ~bpl_pkg::SYNC_BYTE);
      full(5'b01100, bpl_pkg::SYNC_BYTE);
      chk(8'(expq.size()), 8'h00);
      summarize();
   end
   // tests need about 340 us, most of it start-up clock edges; cut off beyond that
   initial begin
      #1ms;
      fails++;
      summarize();
   end
endmodule
